/* hdl/ssta_defines.svh */
// Purpose: constants for the subtract, swap and table access execution block
// Assumes: one Q clock per quarter of an instruction cycle
// Notes:   included by its bare name
`ifndef SSTA_DEFINES_SVH
`define SSTA_DEFINES_SVH

// ****************************************
// instruction cycle quarters
// ****************************************
`define SSTA_Q1              2'h0
`define SSTA_Q2              2'h1
`define SSTA_Q3              2'h2
`define SSTA_Q4              2'h3

// ****************************************
// opcode fields
// ****************************************
`define SSTA_OPC_REV_BORROW  6'h15
`define SSTA_OPC_FILE_BORROW 6'h16
`define SSTA_OPC_FILE_SUB    6'h17
`define SSTA_OPC_SWAP        6'h0E
`define SSTA_OPC_LIT_SUB     8'h08
`define SSTA_OPC_TBL_RD      14'h0002
`define SSTA_OPC_TBL_WR      14'h0003

// ****************************************
// access bank mapping
// ****************************************
`define SSTA_ACCESS_SPLIT    8'h80
`define SSTA_ACCESS_LOW_BANK 4'h0
`define SSTA_ACCESS_HI_BANK  4'hF

// ****************************************
// software register offsets
// ****************************************
`define SSTA_REG_PTR_LO      3'h0
`define SSTA_REG_PTR_HI      3'h1
`define SSTA_REG_PTR_UP      3'h2
`define SSTA_REG_LATCH       3'h3
`define SSTA_REG_WORK        3'h4
`define SSTA_REG_FLAGS       3'h5
`define SSTA_REG_BANK        3'h6
`define SSTA_REG_STATUS      3'h7

// ****************************************
// reset values
// ****************************************
`define SSTA_PTR_RST         21'h000000
`define SSTA_BYTE_RST        8'h00
`define SSTA_BANK_RST        4'h0

`endif

/* hdl/ssta_pkg.sv */
// Purpose: types used by the execution block; its holding memory keeps its own
// Assumes: nothing beyond the constants header
// Notes:   enum order of the table mode matches its 2-bit instruction field
`default_nettype none
package ssta_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_TBL2} ssta_state_e;

   typedef enum logic [2:0] {
      OP_NONE,
      REVERSE_SUBTRACT_BORROW_OP,
      LITERAL_MINUS_WORKING_OP,
      FILE_MINUS_WORKING_OP,
      FILE_MINUS_WORKING_BORROW_OP,
      NIBBLE_SWAP_OP,
      TABLE_READ_OP,
      TABLE_WRITE_OP
   } ssta_op_e;

   typedef enum logic [1:0] {TM_NONE, TM_POSTINC, TM_POSTDEC, TM_PREINC} ssta_tmode_e;

   typedef struct packed {
      logic n;
      logic overflow_flag;
      logic z;
      logic digit_carry_flag;
      logic c;
   } ssta_flags_s;

   typedef struct packed {
      logic [7:0]  res;
      ssta_flags_s fl;
   } ssta_alu_s;

   typedef struct packed {
      ssta_state_e state;
      logic [1:0]  q;
      ssta_op_e    op;
      logic        dest_f;
      logic [7:0]  lit;
      ssta_tmode_e tmode;
      logic [7:0]  w;
      ssta_flags_s flags;
      logic [3:0]  bank_select;
      logic [20:0] table_pointer;
      logic [7:0]  table_latch;
      logic [11:0] f_addr;
      logic        f_rd;
      logic        f_we;
      logic [7:0]  f_wdata;
      logic        pm_rd;
      logic        hold_we;
      logic [7:0]  reg_rdata;
      logic        busy;
   } ssta_core_s;

endpackage
`default_nettype wire

/* hdl/ssta_hold_mem.sv */
// Purpose: holding registers filled by table writes, read by the programmer
// Assumes: single clock, synchronous active-high reset
// Notes:   read data come out of a register, one cycle after the index
`default_nettype none
module ssta_hold_mem #(
   parameter int AW = 3,
   parameter int DW = 8
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // write side
   input  wire logic          we,
   input  wire logic [AW-1:0] widx,
   input  wire logic [DW-1:0] wdata,
   // read side
   input  wire logic [AW-1:0] ridx,
   output logic      [DW-1:0] rdata
);
   typedef struct packed {
      logic [(1<<AW)-1:0][DW-1:0] mem;
      logic [DW-1:0]              rdata;
   } ssta_hold_st_s;

   ssta_hold_st_s r_reg;
   ssta_hold_st_s r_next;

   always_comb begin
      r_next = r_reg;
      r_next.rdata = r_reg.mem[ridx];
      if (we) begin
         r_next.mem[widx] = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rdata = r_reg.rdata;
endmodule
`default_nettype wire

/* hdl/ssta_exec.sv */
// Purpose: executes subtracts, nibble swap and table read/write operations
// Assumes: one CLK per quarter; file and program memory answer one cycle after a read
// Notes:   execution writes win over a software write to the same register
`include "ssta_defines.svh"
`default_nettype none
// Functional notes
// - reverse subtract: W minus f minus not carry
// - literal minus W into W, all flags
// - file minus W to chosen destination
// - swap nibbles of f, flags untouched
// - access bit 0 forces access bank mapping
// - table read fills latch, adjusts pointer
// - pointer bit0 picks low or high byte
// - 21-bit pointer, full width inc/dec
// - table write: latch into holding register
// - write pointer modes, pre-increment before select
module ssta_exec (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // instruction stream
   input  wire logic [15:0] INSTR,
   input  wire logic        INSTR_VALID,
   output logic             BUSY,
   // file register port
   output logic      [11:0] F_ADDR,
   output logic             F_RD,
   input  wire logic [7:0]  F_RDATA,
   output logic             F_WE,
   output logic      [7:0]  F_WDATA,
   // program memory port
   output logic      [20:0] PM_ADDR,
   output logic             PM_RD,
   input  wire logic [15:0] PM_RDATA,
   // holding register readout
   input  wire logic [2:0]  HOLD_IDX,
   output logic      [7:0]  HOLD_DATA,
   // software register port
   input  wire logic [2:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [7:0]  REG_RDATA
);
   ssta_pkg::ssta_core_s r_reg;
   ssta_pkg::ssta_core_s r_next;
   ssta_pkg::ssta_alu_s  alu;

   // ****************************************
   // functions
   // ****************************************
   function automatic ssta_pkg::ssta_alu_s sub8(input logic [7:0] a, input logic [7:0] b,
                                                input logic cin);
      logic [8:0]          s;
      logic [4:0]          h;
      ssta_pkg::ssta_alu_s o;
      // two's complement: a + ~b + carry, carry set means no borrow
      s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      o.res = s[7:0];
      o.fl.c = s[8];
      o.fl.digit_carry_flag = h[4];
      o.fl.z = (s[7:0] == 8'h00);
      o.fl.n = s[7];
      o.fl.overflow_flag = (a[7] ^ b[7]) & (s[7] ^ a[7]);
      return o;
   endfunction

   function automatic ssta_pkg::ssta_op_e decode(input logic [15:0] i);
      decode = ssta_pkg::OP_NONE;
      if (i[15:10] == `SSTA_OPC_REV_BORROW) begin
         decode = ssta_pkg::REVERSE_SUBTRACT_BORROW_OP;
      end else if (i[15:10] == `SSTA_OPC_FILE_BORROW) begin
         decode = ssta_pkg::FILE_MINUS_WORKING_BORROW_OP;
      end else if (i[15:10] == `SSTA_OPC_FILE_SUB) begin
         decode = ssta_pkg::FILE_MINUS_WORKING_OP;
      end else if (i[15:10] == `SSTA_OPC_SWAP) begin
         decode = ssta_pkg::NIBBLE_SWAP_OP;
      end else if (i[15:8] == `SSTA_OPC_LIT_SUB) begin
         decode = ssta_pkg::LITERAL_MINUS_WORKING_OP;
      end else if (i[15:2] == `SSTA_OPC_TBL_RD) begin
         decode = ssta_pkg::TABLE_READ_OP;
      end else if (i[15:2] == `SSTA_OPC_TBL_WR) begin
         decode = ssta_pkg::TABLE_WRITE_OP;
      end
   endfunction

   function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                             input logic [3:0] bank);
      // the access bank ignores bank select entirely
      if (!a) begin
         file_addr = (f < `SSTA_ACCESS_SPLIT) ? {`SSTA_ACCESS_LOW_BANK, f}
                                              : {`SSTA_ACCESS_HI_BANK, f};
      end else begin
         file_addr = {bank, f};
      end
   endfunction

   function automatic logic is_file_op(input ssta_pkg::ssta_op_e op);
      is_file_op = (op == ssta_pkg::REVERSE_SUBTRACT_BORROW_OP) ||
                   (op == ssta_pkg::FILE_MINUS_WORKING_BORROW_OP) ||
                   (op == ssta_pkg::FILE_MINUS_WORKING_OP) ||
                   (op == ssta_pkg::NIBBLE_SWAP_OP);
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      r_next = r_reg;
      r_next.q = r_reg.q + 2'h1;
      r_next.f_rd = 1'b0;
      r_next.f_we = 1'b0;
      r_next.pm_rd = 1'b0;
      r_next.hold_we = 1'b0;
      r_next.reg_rdata = 8'h00;
      alu = '0;
      if (REG_RD) begin
         case (REG_ADDR)
            `SSTA_REG_PTR_LO: r_next.reg_rdata = r_reg.table_pointer[7:0];
            `SSTA_REG_PTR_HI: r_next.reg_rdata = r_reg.table_pointer[15:8];
            `SSTA_REG_PTR_UP: r_next.reg_rdata = {3'h0, r_reg.table_pointer[20:16]};
            `SSTA_REG_LATCH:  r_next.reg_rdata = r_reg.table_latch;
            `SSTA_REG_WORK:   r_next.reg_rdata = r_reg.w;
            `SSTA_REG_FLAGS:  r_next.reg_rdata = {3'h0, r_reg.flags};
            `SSTA_REG_BANK:   r_next.reg_rdata = {4'h0, r_reg.bank_select};
            default:          r_next.reg_rdata = {7'h00, r_reg.busy};
         endcase
      end
      if (REG_WR) begin
         case (REG_ADDR)
            `SSTA_REG_PTR_LO: r_next.table_pointer[7:0] = REG_WDATA;
            `SSTA_REG_PTR_HI: r_next.table_pointer[15:8] = REG_WDATA;
            `SSTA_REG_PTR_UP: r_next.table_pointer[20:16] = REG_WDATA[4:0];
            `SSTA_REG_LATCH:  r_next.table_latch = REG_WDATA;
            `SSTA_REG_WORK:   r_next.w = REG_WDATA;
            `SSTA_REG_FLAGS:  r_next.flags = REG_WDATA[4:0];
            `SSTA_REG_BANK:   r_next.bank_select = REG_WDATA[3:0];
            default:          r_next.busy = r_reg.busy;
         endcase
      end
      case (r_reg.state)
         ssta_pkg::ST_IDLE: begin
            if (r_reg.q == `SSTA_Q1 && INSTR_VALID) begin
               r_next.op = decode(INSTR);
               r_next.dest_f = INSTR[9];
               r_next.lit = INSTR[7:0];
               r_next.tmode = ssta_pkg::ssta_tmode_e'(INSTR[1:0]);
               r_next.state = ssta_pkg::ST_EXEC;
               r_next.busy = 1'b1;
               r_next.f_rd = is_file_op(decode(INSTR));
               r_next.f_addr = file_addr(INSTR[8], INSTR[7:0], r_reg.bank_select);
            end
         end
         ssta_pkg::ST_EXEC: begin
            if (r_reg.q == `SSTA_Q3) begin
               case (r_reg.op)
                  ssta_pkg::REVERSE_SUBTRACT_BORROW_OP:
                     alu = sub8(r_reg.w, F_RDATA, r_reg.flags.c);
                  ssta_pkg::FILE_MINUS_WORKING_BORROW_OP:
                     alu = sub8(F_RDATA, r_reg.w, r_reg.flags.c);
                  ssta_pkg::FILE_MINUS_WORKING_OP:
                     alu = sub8(F_RDATA, r_reg.w, 1'b1);
                  ssta_pkg::LITERAL_MINUS_WORKING_OP:
                     alu = sub8(r_reg.lit, r_reg.w, 1'b1);
                  default: begin
                     alu.res = {F_RDATA[3:0], F_RDATA[7:4]};
                     alu.fl = r_reg.flags;
                  end
               endcase
               if (is_file_op(r_reg.op) || r_reg.op == ssta_pkg::LITERAL_MINUS_WORKING_OP) begin
                  // flags stay put for the swap since alu.fl carries them through
                  r_next.flags = alu.fl;
                  if (r_reg.dest_f && r_reg.op != ssta_pkg::LITERAL_MINUS_WORKING_OP) begin
                     r_next.f_we = 1'b1;
                     r_next.f_wdata = alu.res;
                  end else begin
                     r_next.w = alu.res;
                  end
               end
            end else if (r_reg.q == `SSTA_Q4) begin
               if (r_reg.op == ssta_pkg::TABLE_READ_OP || r_reg.op == ssta_pkg::TABLE_WRITE_OP) begin
                  r_next.state = ssta_pkg::ST_TBL2;
                  if (r_reg.tmode == ssta_pkg::TM_PREINC) begin
                     r_next.table_pointer = r_reg.table_pointer + 21'h000001;
                  end
               end else begin
                  r_next.state = ssta_pkg::ST_IDLE;
                  r_next.busy = 1'b0;
               end
            end
         end
         ssta_pkg::ST_TBL2: begin
            if (r_reg.q == `SSTA_Q1) begin
               r_next.pm_rd = (r_reg.op == ssta_pkg::TABLE_READ_OP);
            end else if (r_reg.q == `SSTA_Q3) begin
               if (r_reg.op == ssta_pkg::TABLE_READ_OP) begin
                  r_next.table_latch = r_reg.table_pointer[0] ? PM_RDATA[15:8]
                                                              : PM_RDATA[7:0];
               end else begin
                  r_next.hold_we = 1'b1;
               end
            end else if (r_reg.q == `SSTA_Q4) begin
               // post modes move the pointer only after the transfer
               if (r_reg.tmode == ssta_pkg::TM_POSTINC) begin
                  r_next.table_pointer = r_reg.table_pointer + 21'h000001;
               end else if (r_reg.tmode == ssta_pkg::TM_POSTDEC) begin
                  r_next.table_pointer = r_reg.table_pointer - 21'h000001;
               end
               r_next.state = ssta_pkg::ST_IDLE;
               r_next.busy = 1'b0;
            end
         end
         default: begin
            r_next.state = ssta_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   ssta_hold_mem #(.AW(3), .DW(8)) u_hold (
      .clk   (CLK),
      .rst   (RST),
      .we    (r_reg.hold_we),
      .widx  (r_reg.table_pointer[2:0]),
      .wdata (r_reg.table_latch),
      .ridx  (HOLD_IDX),
      .rdata (HOLD_DATA)
   );

   assign BUSY      = r_reg.busy;
   assign F_ADDR    = r_reg.f_addr;
   assign F_RD      = r_reg.f_rd;
   assign F_WE      = r_reg.f_we;
   assign F_WDATA   = r_reg.f_wdata;
   assign PM_ADDR   = r_reg.table_pointer;
   assign PM_RD     = r_reg.pm_rd;
   assign REG_RDATA = r_reg.reg_rdata;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   a_tbl_two_cycles: assert property ((r_reg.state == ssta_pkg::ST_EXEC && r_reg.q == `SSTA_Q2 &&
      (r_reg.op == ssta_pkg::TABLE_READ_OP || r_reg.op == ssta_pkg::TABLE_WRITE_OP))
      |-> BUSY [*7] ##1 !BUSY)
      else $error("table op not eight quarters long");
   a_pm_read_q2: assert property (PM_RD |-> r_reg.q == `SSTA_Q2 && r_reg.state == ssta_pkg::ST_TBL2
      && r_reg.op == ssta_pkg::TABLE_READ_OP)
      else $error("program memory read outside second quarter");
   a_latch_byte: assert property ((r_reg.state == ssta_pkg::ST_TBL2 && r_reg.q == `SSTA_Q4 &&
      r_reg.op == ssta_pkg::TABLE_READ_OP) |-> r_reg.table_latch ==
      (PM_ADDR[0] ? $past(PM_RDATA[15:8]) : $past(PM_RDATA[7:0])))
      else $error("table latch took wrong byte");
   a_post_inc: assert property ((r_reg.state == ssta_pkg::ST_TBL2 && r_reg.q == `SSTA_Q4 &&
      r_reg.tmode == ssta_pkg::TM_POSTINC) |=> PM_ADDR == $past(PM_ADDR) + 21'h000001)
      else $error("post increment wrong");
   a_pre_inc: assert property ((r_reg.state == ssta_pkg::ST_EXEC && r_reg.q == `SSTA_Q4 &&
      r_reg.op == ssta_pkg::TABLE_WRITE_OP && r_reg.tmode == ssta_pkg::TM_PREINC)
      |=> PM_ADDR == $past(PM_ADDR) + 21'h000001)
      else $error("pre increment wrong");
   a_swap_data: assert property ((F_WE && r_reg.op == ssta_pkg::NIBBLE_SWAP_OP) |->
      F_WDATA == {$past(F_RDATA[3:0]), $past(F_RDATA[7:4])} && $stable(r_reg.flags))
      else $error("swap data or flags wrong");
   a_lit_sub: assert property ((r_reg.state == ssta_pkg::ST_EXEC && r_reg.q == `SSTA_Q4 &&
      r_reg.op == ssta_pkg::LITERAL_MINUS_WORKING_OP) |->
      r_reg.w == 8'(r_reg.lit - $past(r_reg.w)) && r_reg.flags.z == (r_reg.w == 8'h00))
      else $error("literal subtract wrong");
   a_sub_flags: assert property ((F_WE && r_reg.op != ssta_pkg::NIBBLE_SWAP_OP) |->
      r_reg.flags.z == (F_WDATA == 8'h00) && r_reg.flags.n == F_WDATA[7])
      else $error("subtract flags wrong");
   a_access_bank: assert property ((F_RD && !$past(INSTR[8])) |-> F_ADDR[11:8] ==
      (F_ADDR[7:0] < `SSTA_ACCESS_SPLIT ? `SSTA_ACCESS_LOW_BANK : `SSTA_ACCESS_HI_BANK))
      else $error("access bank mapping wrong");

   c_tbl_read: cover property (PM_RD ##3 !BUSY);
   c_tbl_write: cover property (r_reg.hold_we);
   c_file_write: cover property (F_WE && r_reg.op == ssta_pkg::REVERSE_SUBTRACT_BORROW_OP);
endmodule
`default_nettype wire

/* verification/ssta_far_model.sv */
// Purpose: file registers and program memory facing the execution block
// Assumes: read data answered in the cycle after the read pulse
// Notes:   idle data lines toggle so a late sample never matches
`default_nettype none
module ssta_far_model (
   // clock
   input  wire logic        clk,
   // file register side
   input  wire logic [11:0] f_addr,
   input  wire logic        f_rd,
   input  wire logic        f_we,
   input  wire logic [7:0]  f_wdata,
   output logic      [7:0]  f_rdata,
   // program memory side
   input  wire logic [20:0] pm_addr,
   input  wire logic        pm_rd,
   output logic      [15:0] pm_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] fmem [0:4095];

   // word content derived from its word address, no 2 Mbyte array needed
   function automatic logic [15:0] word_at(input logic [19:0] wa);
      return {wa[7:0] ^ 8'hC3, wa[12:5]};
   endfunction

   initial begin
      f_rdata = 8'h00;
      pm_rdata = 16'h0000;
   end

   always @(posedge clk) begin
      f_rdata <= f_rd ? fmem[f_addr] : ~f_rdata;
      pm_rdata <= pm_rd ? word_at(pm_addr[20:1]) : ~pm_rdata;
      if (f_we) begin
         fmem[f_addr] <= f_wdata;
      end
   end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: self-checking bench for the subtract, swap and table block
// Assumes: one CLK per quarter, bench drives on the rising edge
// Notes:   reference state kept in plain variables beside the design
`include "ssta_defines.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // signals
   // ****************************************
   logic        CLK, RST, INSTR_VALID, BUSY, F_RD, F_WE, PM_RD, REG_WR, REG_RD;
   logic [15:0] INSTR, PM_RDATA;
   logic [11:0] F_ADDR, fa;
   logic [7:0]  F_RDATA, F_WDATA, HOLD_DATA, REG_WDATA, REG_RDATA;
   logic [20:0] PM_ADDR, rptr, p;
   logic [2:0]  HOLD_IDX, REG_ADDR;
   logic [7:0]  rw, rlat, r, fv, f, d, fl, rf;
   logic [7:0]  rhold [8];
   logic [3:0]  rbank;
   logic        rc, rn, rov, rz, rdc, dd, aa;
   int          errors, n_compared, cycles, op, md, wr, n;

   ssta_exec u_ssta_exec (.CLK(CLK), .RST(RST), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
      .BUSY(BUSY), .F_ADDR(F_ADDR), .F_RD(F_RD), .F_RDATA(F_RDATA), .F_WE(F_WE),
      .F_WDATA(F_WDATA), .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .PM_RDATA(PM_RDATA),
      .HOLD_IDX(HOLD_IDX), .HOLD_DATA(HOLD_DATA), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
   ssta_far_model u_ssta_far_model (.clk(CLK), .f_addr(F_ADDR), .f_rd(F_RD), .f_we(F_WE),
      .f_wdata(F_WDATA), .f_rdata(F_RDATA), .pm_addr(PM_ADDR), .pm_rd(PM_RD),
      .pm_rdata(PM_RDATA));

   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   // about 20 to 30 cycles per operation; the ceiling leaves a wide margin
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         finish_test();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic finish_test();
      if (errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [20:0] exp, input logic [20:0] seen);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
      REG_ADDR <= a;
      REG_WDATA <= v;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1;
      v = REG_RDATA;
      @(posedge CLK);
   endtask

   task automatic wait_busy(input logic lvl, output int cnt);
      cnt = 0;
      do begin
         @(posedge CLK);
         #1;
         cnt++;
      end while (BUSY !== lvl && cnt < 12);
   endtask

   // valid stays up until the op is taken, then drops well before the next Q1
   task automatic run_op(input logic [15:0] ins, input int busy_len);
      INSTR <= ins;
      INSTR_VALID <= 1'b1;
      wait_busy(1'b1, n);
      @(posedge CLK);
      INSTR_VALID <= 1'b0;
      wait_busy(1'b0, n);
      check("busy length", busy_len, n);
      @(posedge CLK);
   endtask

   task automatic check_state();
      reg_rd(`SSTA_REG_WORK, d);
      check("working value", rw, d);
      reg_rd(`SSTA_REG_FLAGS, d);
      check("flags", {rn, rov, rz, rdc, rc}, d);
      reg_rd(`SSTA_REG_LATCH, d);
      check("table latch", rlat, d);
      check("table pointer", rptr, PM_ADDR);
   endtask

   task automatic ref_sub(input int a, input int b, input int cin);
      int x;
      x = a - b - (1 - cin);
      r = x[7:0];
      rc = (x >= 0);
      rdc = ((a % 16) - (b % 16) - (1 - cin)) >= 0;
      rov = (a[7] != b[7]) && (r[7] != a[7]);
      rn = r[7];
      rz = (r == 8'h00);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h90242BA2));
      {RST, INSTR_VALID, REG_WR, REG_RD} = 4'hF;
      {INSTR_VALID, REG_WR, REG_RD} = 3'h0;
      {INSTR, HOLD_IDX, REG_ADDR, REG_WDATA} = '0;
      {errors, n_compared, cycles} = '0;
      {rw, rlat, rptr, rbank, rc, rn, rov, rz, rdc} = '0;
      for (int i = 0; i < 8; i++) rhold[i] = 8'h00;
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      check_state();
      for (int k = 0; k < 60; k++) begin
         op = $urandom_range(0, 5);
         {dd, aa, f, fv, rw, fl, rbank} = {$urandom, $urandom};
         if (k < 4) begin
            f = 8'h7F + k[0];
            aa = k[1];
         end
         {rn, rov, rz, rdc, rc} = fl[4:0];
         reg_wr(`SSTA_REG_WORK, rw);
         reg_wr(`SSTA_REG_FLAGS, fl);
         reg_wr(`SSTA_REG_BANK, {4'h0, rbank});
         fa = aa ? {rbank, f} : {(f < `SSTA_ACCESS_SPLIT) ? 4'h0 : 4'hF, f};
         u_ssta_far_model.fmem[fa] = fv;
         case (op)
            0: ref_sub(rw, fv, rc);
            1: ref_sub(f, rw, 1);
            2: ref_sub(fv, rw, 1);
            3: ref_sub(fv, rw, rc);
            4: r = {fv[3:0], fv[7:4]};
            // an undecoded word must leave W, flags and the file byte alone
            default: {dd, r} = {1'b0, rw};
         endcase
         case (op)
            0: run_op({`SSTA_OPC_REV_BORROW, dd, aa, f}, 2);
            1: run_op({`SSTA_OPC_LIT_SUB, f}, 2);
            2: run_op({`SSTA_OPC_FILE_SUB, dd, aa, f}, 2);
            3: run_op({`SSTA_OPC_FILE_BORROW, dd, aa, f}, 2);
            4: run_op({`SSTA_OPC_SWAP, dd, aa, f}, 2);
            default: run_op(16'hFFFF, 2);
         endcase
         rf = (dd && op != 1) ? r : fv;
         rw = (dd && op != 1) ? rw : r;
         check_state();
         check("file byte", rf, u_ssta_far_model.fmem[fa]);
      end
      for (int k = 0; k < 32; k++) begin
         md = k % 4;
         wr = k / 8 % 2;
         p = (k >= 16) ? 21'($urandom) : (k % 8 < 4) ? 21'h1FFFFF : 21'h000000;
         rptr = p;
         rlat = $urandom;
         reg_wr(`SSTA_REG_PTR_LO, p[7:0]);
         reg_wr(`SSTA_REG_PTR_HI, p[15:8]);
         reg_wr(`SSTA_REG_PTR_UP, {3'h0, p[20:16]});
         reg_wr(`SSTA_REG_LATCH, rlat);
         if (md == 3) p = p + 21'h1;
         if (wr == 1) rhold[p[2:0]] = rlat;
         else rlat = p[0] ? p[8:1] ^ 8'hC3 : p[13:6];
         rptr = (md == 1) ? p + 21'h1 : (md == 2) ? p - 21'h1 : p;
         run_op({wr ? `SSTA_OPC_TBL_WR : `SSTA_OPC_TBL_RD, 2'(md)}, 6);
         check_state();
         reg_rd(`SSTA_REG_PTR_UP, d);
         check("pointer upper", {3'h0, rptr[20:16]}, d);
      end
      for (int i = 0; i < 8; i++) begin
         HOLD_IDX <= 3'(i);
         @(posedge CLK);
         #1;
         check("holding register", rhold[i], HOLD_DATA);
         @(posedge CLK);
      end
      reg_wr(`SSTA_REG_STATUS, 8'hFF);
      reg_rd(`SSTA_REG_STATUS, d);
      check("status", 8'h00, d);
      finish_test();
   end
endmodule
`default_nettype wire
